// ==== rtl/tceip_consts.vh ====
// Constants of the 16-bit timer slice: register indices, fields, resets.
// Assumes byte address of a register is four times its index.
`ifndef TCEIP_CONSTS_VH
`define TCEIP_CONSTS_VH

// ==========================================================
// Register indices (byte address = index * 4)
`define TCEIP_IDX_PORT0_DIR      16'hFF20
`define TCEIP_IDX_PRESCALE_EDGE  16'hFFBB
`define TCEIP_IDX_MODE_CTRL      16'hFF10
`define TCEIP_IDX_OUTPUT_CTRL    16'hFF11
`define TCEIP_IDX_FIRST_CMP      16'hFF12
`define TCEIP_IDX_SECOND_CMP     16'hFF13
`define TCEIP_IDX_STATUS         16'hFF14
`define TCEIP_IDX_PORT0_LATCH    16'hFF15

// ==========================================================
// Reset values
`define TCEIP_RST_PORT0_DIR      4'hF
`define TCEIP_RST_PRESCALE_EDGE  8'h00
`define TCEIP_PORT0_DIR_UPPER    4'hF

// ==========================================================
// Prescale/edge register fields
`define TCEIP_CLKSEL_LSB         0
`define TCEIP_FIRST_EDGE_LSB     4
`define TCEIP_SECOND_EDGE_LSB    6

// Count clock selections
`define TCEIP_CLK_DIV1           2'h0
`define TCEIP_CLK_DIV4           2'h1
`define TCEIP_CLK_DIV256         2'h2
`define TCEIP_CLK_EXT_EDGE       2'h3

// Edge selections
`define TCEIP_EDGE_FALL          2'h0
`define TCEIP_EDGE_RISE          2'h1
`define TCEIP_EDGE_BOTH          2'h3

// Timer modes
`define TCEIP_MODE_STOP          2'h0
`define TCEIP_MODE_FREE          2'h1
`define TCEIP_MODE_INTERVAL      2'h2
`define TCEIP_MODE_PULSE         2'h3

// ==========================================================
// Status register fields
`define TCEIP_ST_OVERFLOW        16
`define TCEIP_ST_MATCH           17
`define TCEIP_ST_FIRST_EDGE      18
`define TCEIP_ST_SECOND_EDGE     19

// Prescaler taps and shared pin index
`define TCEIP_DIV4_MASK          8'h03
`define TCEIP_DIV256_MASK        8'hFF
`define TCEIP_SHARED_PIN         1

`endif

// ==== rtl/tceip_edge.v ====
// Timer input edge detector: synchroniser, two-sample filter, edge select.
// Assumes sample strobes come from the selected count clock, or every system clock when counting external edges.
`timescale 1ns/1ps
`include "tceip_consts.vh"

module TCEIP_edge (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       pin_in,
    input  wire       sample,
    input  wire       arm,
    input  wire       hold_low,
    input  wire [1:0] sel,
    output reg        valid_edge_ff
);

    reg sync1_ff;
    reg sync2_ff;
    reg last_ff;
    reg filt_ff;

    // ==========================================================
    // Edge qualification
    function edge_ok;
        input [1:0] s;
        input       rising;
        begin
            case (s)
                `TCEIP_EDGE_FALL: edge_ok = ~rising;
                `TCEIP_EDGE_RISE: edge_ok = rising;
                `TCEIP_EDGE_BOTH: edge_ok = 1'b1;
                default:          edge_ok = 1'b0;
            endcase
        end
    endfunction

    always @(posedge clk) begin
        if (!rst_n) begin
            sync1_ff      <= 1'b0;
            sync2_ff      <= 1'b0;
            last_ff       <= 1'b0;
            filt_ff       <= 1'b0;
            valid_edge_ff <= 1'b0;
        end else begin
            sync1_ff      <= pin_in;                        // [RL25]
            sync2_ff      <= sync1_ff;                      // [RL25]
            valid_edge_ff <= 1'b0;
            if (hold_low) begin
                // Level seen as low until first start
                filt_ff <= 1'b0;                            // [RL8]
                last_ff <= sync2_ff;
            end else if (!arm) begin
                filt_ff <= sync2_ff;                        // [RL9]
                last_ff <= sync2_ff;
            end else if (sample) begin
                last_ff <= sync2_ff;
                if (sync2_ff == last_ff && sync2_ff != filt_ff) begin
                    filt_ff       <= sync2_ff;              // [RL24]
                    valid_edge_ff <= edge_ok(sel, sync2_ff); // [RL2] [RL3]
                end
            end
        end
    end

endmodule

// ==== rtl/tceip_timer.v ====
// 16-bit timer/event counter slice with AHB-Lite register access.
// Assumes a single AHB-Lite master and timer pins synchronous to CLOCK.
//
// Overview of operation
// RL1 - Clock select picks system clock, /4, /256 or first input valid edge.
// RL2 - First input edge codes: 00 falling, 01 rising, 11 both; 10 forbidden.
// RL3 - Second input edge bits 7:6 use same coding; 10 forbidden.
// RL4 - Prescale/edge register resets to zero; bit or byte writable.
// RL5 - External count pulses last two system clocks longer than internal.
// RL6 - Software writes prescale/edge register only while timer stopped.
// RL7 - First input count clock excludes clear-on-edge and capture use.
// RL8 - Input high after reset yields rising edge at first enable.
// RL9 - Re-enable after stop reports no rising edge for high input.
// RL10 - Shared pin is second input or timer output, never both.
// RL11 - Direction bit 0 drives output, 1 is input; upper bits read 1.
// RL12 - Direction register resets to all ones; bit or byte writable.
// RL13 - Timer output on shared pin needs direction bit and latch 0.
// RL14 - Shared pin as input needs direction bit 1; latch ignored.
// RL15 - Interval mode: match clears counter, keeps counting, raises request.
// RL16 - Interval is compare plus one count clocks; compare 0001 to FFFF.
// RL17 - Interval mode sets overflow flag only when compare is FFFF.
// RL18 - Software does not rewrite first compare during interval counting.
// RL19 - Interval setup order: compare control, compare, clock, mode.
// RL20 - Pulse mode: cycle from first compare, width from second.
// RL21 - Pulse setup order: control, cycle, width, output, clock, mode.
// RL22 - Output enable 0 holds timer output low; 1 follows output flop.
// RL23 - Width below cycle; cycle is cycle+1 counts, high width+1 counts.
// RL24 - Edge accepted after valid level is sampled twice by count clock.
// RL25 - Both timer inputs are synchronised before edge detection.
// RL26 - Counter advances per tick, wraps FFFF to 0000 and sets overflow.
`timescale 1ns/1ps
`include "tceip_consts.vh"

module TCEIP_timer (
    input  wire        CLOCK,
    input  wire        RESET_N,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output reg  [31:0] HRDATA,
    output reg         HREADYOUT,
    output reg         HRESP,
    input  wire        FIRST_TIMER_INPUT,
    input  wire [3:0]  PORT0_IN,
    output reg  [3:0]  PORT0_OUT,
    output reg  [3:0]  PORT0_OE,
    output reg         COMPARE_MATCH_INTERRUPT
);

    // ==========================================================
    // Registers
    reg  [7:0]  prescale_edge_ff;
    reg  [3:0]  port0_dir_ff;
    reg  [3:0]  port0_latch_ff;
    reg  [1:0]  mode_ff;
    reg         output_enable_ff;
    reg  [15:0] first_cmp_ff;
    reg  [15:0] second_cmp_ff;
    reg  [15:0] counter_ff;
    reg         overflow_ff;
    reg         match_ff;
    reg         first_edge_seen_ff;
    reg         second_edge_seen_ff;
    reg  [7:0]  prescaler_ff;
    reg         started_ff;
    reg         pulse_ff;

    reg         wr_pend_ff;
    reg  [15:0] wr_idx_ff;
    reg  [31:0] wr_mask_ff;

    wire        first_edge;
    wire        second_edge;

    reg  [31:0] nxt_rdata;
    reg         tick;
    reg         sample;

    // ==========================================================
    // Bus helpers
    function [31:0] lane_mask;
        input [2:0] size;
        input [1:0] addr_lo;
        begin
            case (size)
                3'h0:    lane_mask = 32'h0000_00FF << {addr_lo, 3'h0};
                3'h1:    lane_mask = 32'h0000_FFFF << {addr_lo[1], 4'h0};
                default: lane_mask = 32'hFFFF_FFFF;
            endcase
        end
    endfunction

    function [31:0] merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [31:0] mask;
        begin
            merge = (old_val & ~mask) | (new_val & mask);
        end
    endfunction

    wire        addr_phase = HSEL & HREADY & HTRANS[1];
    wire        in_range   = (HADDR[31:18] == 14'h0000);
    wire [15:0] addr_idx   = HADDR[17:2];
    wire        running    = (mode_ff != `TCEIP_MODE_STOP);
    wire [1:0]  clk_sel    = prescale_edge_ff[`TCEIP_CLKSEL_LSB +: 2];
    wire        wr_go      = wr_pend_ff;

    wire [31:0] img_dir    = {24'h0, `TCEIP_PORT0_DIR_UPPER, port0_dir_ff};
    wire [31:0] img_pre    = {24'h0, prescale_edge_ff};
    wire [31:0] img_mode   = {30'h0, mode_ff};
    wire [31:0] img_out    = {31'h0, output_enable_ff};
    wire [31:0] img_cmp0   = {16'h0, first_cmp_ff};
    wire [31:0] img_cmp1   = {16'h0, second_cmp_ff};
    wire [31:0] img_latch  = {28'h0, port0_latch_ff};
    wire [31:0] img_status = {12'h0, second_edge_seen_ff, first_edge_seen_ff,
                              match_ff, overflow_ff, counter_ff};

    wire [31:0] m_dir   = merge(img_dir,   HWDATA, wr_mask_ff);
    wire [31:0] m_pre   = merge(img_pre,   HWDATA, wr_mask_ff);
    wire [31:0] m_mode  = merge(img_mode,  HWDATA, wr_mask_ff);
    wire [31:0] m_out   = merge(img_out,   HWDATA, wr_mask_ff);
    wire [31:0] m_cmp0  = merge(img_cmp0,  HWDATA, wr_mask_ff);
    wire [31:0] m_cmp1  = merge(img_cmp1,  HWDATA, wr_mask_ff);
    wire [31:0] m_latch = merge(img_latch, HWDATA, wr_mask_ff);
    wire [31:0] clr     = HWDATA & wr_mask_ff;

    wire wr_dir   = wr_go && wr_idx_ff == `TCEIP_IDX_PORT0_DIR;
    wire wr_pre   = wr_go && wr_idx_ff == `TCEIP_IDX_PRESCALE_EDGE;
    wire wr_mode  = wr_go && wr_idx_ff == `TCEIP_IDX_MODE_CTRL;
    wire wr_out   = wr_go && wr_idx_ff == `TCEIP_IDX_OUTPUT_CTRL;
    wire wr_cmp0  = wr_go && wr_idx_ff == `TCEIP_IDX_FIRST_CMP;
    wire wr_cmp1  = wr_go && wr_idx_ff == `TCEIP_IDX_SECOND_CMP;
    wire wr_stat  = wr_go && wr_idx_ff == `TCEIP_IDX_STATUS;
    wire wr_latch = wr_go && wr_idx_ff == `TCEIP_IDX_PORT0_LATCH;

    // ==========================================================
    // Read data, registered during the address phase
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (addr_phase && !HWRITE && in_range) begin
            case (addr_idx)
                `TCEIP_IDX_PORT0_DIR:     nxt_rdata = img_dir;    // [RL11]
                `TCEIP_IDX_PRESCALE_EDGE: nxt_rdata = img_pre;
                `TCEIP_IDX_MODE_CTRL:     nxt_rdata = img_mode;
                `TCEIP_IDX_OUTPUT_CTRL:   nxt_rdata = img_out;
                `TCEIP_IDX_FIRST_CMP:     nxt_rdata = img_cmp0;
                `TCEIP_IDX_SECOND_CMP:    nxt_rdata = img_cmp1;
                `TCEIP_IDX_STATUS:        nxt_rdata = img_status;
                `TCEIP_IDX_PORT0_LATCH:   nxt_rdata = img_latch;
                default:                  nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            HRDATA     <= 32'h0000_0000;
            HREADYOUT  <= 1'b1;
            HRESP      <= 1'b0;
            wr_pend_ff <= 1'b0;
            wr_idx_ff  <= 16'h0000;
            wr_mask_ff <= 32'h0000_0000;
        end else begin
            HRDATA     <= nxt_rdata;
            HREADYOUT  <= 1'b1;
            HRESP      <= 1'b0;
            wr_pend_ff <= addr_phase & HWRITE & in_range;
            wr_idx_ff  <= addr_idx;
            wr_mask_ff <= lane_mask(HSIZE, HADDR[1:0]);
        end
    end

    // ==========================================================
    // Count clock selection
    always @* begin
        case (clk_sel)                                          // [RL1]
            `TCEIP_CLK_DIV1:   tick = running;
            `TCEIP_CLK_DIV4:   tick = running &&
                ((prescaler_ff & `TCEIP_DIV4_MASK) == `TCEIP_DIV4_MASK);
            `TCEIP_CLK_DIV256: tick = running &&
                (prescaler_ff == `TCEIP_DIV256_MASK);
            default:           tick = running && first_edge;
        endcase
        // External edge count samples at system rate
        sample = (clk_sel == `TCEIP_CLK_EXT_EDGE) ? 1'b1 : tick; // [RL24]
    end

    // ==========================================================
    // Input edge detectors
    TCEIP_edge u_first_edge (
        .clk           (CLOCK),
        .rst_n         (RESET_N),
        .pin_in        (FIRST_TIMER_INPUT),
        .sample        (sample),
        .arm           (running),
        .hold_low      (~started_ff),
        .sel           (prescale_edge_ff[`TCEIP_FIRST_EDGE_LSB +: 2]),
        .valid_edge_ff (first_edge)
    );

    // Shared pin counts as an input only in input mode
    TCEIP_edge u_second_edge (
        .clk           (CLOCK),
        .rst_n         (RESET_N),
        .pin_in        (PORT0_IN[`TCEIP_SHARED_PIN] &
                        port0_dir_ff[`TCEIP_SHARED_PIN]),   // [RL10] [RL14]
        .sample        (sample),
        .arm           (running & port0_dir_ff[`TCEIP_SHARED_PIN]),
        .hold_low      (~started_ff),
        .sel           (prescale_edge_ff[`TCEIP_SECOND_EDGE_LSB +: 2]),
        .valid_edge_ff (second_edge)
    );

    // ==========================================================
    // Control registers
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            prescale_edge_ff <= `TCEIP_RST_PRESCALE_EDGE;       // [RL4]
            port0_dir_ff     <= `TCEIP_RST_PORT0_DIR;           // [RL12]
            port0_latch_ff   <= 4'h0;
            mode_ff          <= `TCEIP_MODE_STOP;
            output_enable_ff <= 1'b0;
            first_cmp_ff     <= 16'h0000;
            second_cmp_ff    <= 16'h0000;
            started_ff       <= 1'b0;
        end else begin
            if (wr_pre)
                prescale_edge_ff <= m_pre[7:0];                 // [RL4]
            if (wr_dir)
                port0_dir_ff <= m_dir[3:0];                     // [RL12]
            if (wr_latch)
                port0_latch_ff <= m_latch[3:0];
            if (wr_mode)
                mode_ff <= m_mode[1:0];
            if (wr_out)
                output_enable_ff <= m_out[0];
            if (wr_cmp0)
                first_cmp_ff <= m_cmp0[15:0];
            if (wr_cmp1)
                second_cmp_ff <= m_cmp1[15:0];
            if (running)
                started_ff <= 1'b1;                             // [RL8]
        end
    end

    // ==========================================================
    // Counter, compare and pulse generation
    wire clear_mode = (mode_ff == `TCEIP_MODE_INTERVAL) ||
                      (mode_ff == `TCEIP_MODE_PULSE);
    wire cmp0_hit   = tick && (counter_ff == first_cmp_ff);
    wire do_clear   = cmp0_hit && clear_mode;
    wire wrap       = tick && !do_clear && (counter_ff == 16'hFFFF);
    wire ovf_set    = wrap ||
                      (do_clear && first_cmp_ff == 16'hFFFF);

    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            counter_ff              <= 16'h0000;
            prescaler_ff            <= 8'h00;
            pulse_ff                <= 1'b0;
            COMPARE_MATCH_INTERRUPT <= 1'b0;
        end else begin
            COMPARE_MATCH_INTERRUPT <= cmp0_hit;                // [RL15]
            if (!running) begin
                counter_ff   <= 16'h0000;
                prescaler_ff <= 8'h00;
                pulse_ff     <= (wr_mode &&
                    m_mode[1:0] == `TCEIP_MODE_PULSE);          // [RL20]
            end else begin
                prescaler_ff <= prescaler_ff + 8'h01;
                if (do_clear) begin
                    counter_ff <= 16'h0000;                     // [RL15] [RL16]
                    pulse_ff   <= 1'b1;                         // [RL23]
                end else if (tick) begin
                    counter_ff <= counter_ff + 16'h0001;        // [RL26]
                    if (counter_ff == second_cmp_ff)
                        pulse_ff <= 1'b0;                       // [RL20] [RL23]
                end
            end
        end
    end

    // ==========================================================
    // Status flags; a hardware set wins over a software clear
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            overflow_ff         <= 1'b0;
            match_ff            <= 1'b0;
            first_edge_seen_ff  <= 1'b0;
            second_edge_seen_ff <= 1'b0;
        end else begin
            overflow_ff <= ovf_set |                            // [RL17] [RL26]
                (overflow_ff & ~(wr_stat & clr[`TCEIP_ST_OVERFLOW]));
            match_ff <= cmp0_hit |
                (match_ff & ~(wr_stat & clr[`TCEIP_ST_MATCH]));
            first_edge_seen_ff <= first_edge |
                (first_edge_seen_ff &
                 ~(wr_stat & clr[`TCEIP_ST_FIRST_EDGE]));
            second_edge_seen_ff <= second_edge |
                (second_edge_seen_ff &
                 ~(wr_stat & clr[`TCEIP_ST_SECOND_EDGE]));
        end
    end

    // ==========================================================
    // Port 0 pins
    wire timer_level = output_enable_ff &
                       (mode_ff == `TCEIP_MODE_PULSE) & pulse_ff; // [RL22]

    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            PORT0_OUT <= 4'h0;
            PORT0_OE  <= 4'h0;
        end else begin
            PORT0_OE  <= ~port0_dir_ff;                         // [RL11]
            PORT0_OUT <= port0_latch_ff |
                ({3'h0, timer_level} << `TCEIP_SHARED_PIN);     // [RL10]
        end
    end

endmodule

// ==== tb/tceip_timer_assertions.sv ====
// Checker for the timer slice, bound to its top module.
// Assumes zero-wait AHB-Lite and the indices of the consts header.
`timescale 1ns/1ps
`include "tceip_consts.vh"

module TCEIP_timer_chk (
    input logic        CLOCK,
    input logic        RESET_N,
    input logic        HSEL,
    input logic [31:0] HADDR,
    input logic [1:0]  HTRANS,
    input logic        HWRITE,
    input logic [31:0] HWDATA,
    input logic        HREADY,
    input logic [31:0] HRDATA,
    input logic        HREADYOUT,
    input logic        HRESP,
    input logic [3:0]  PORT0_OE,
    input logic        COMPARE_MATCH_INTERRUPT
);
    wire        req = HSEL & HREADY & HTRANS[1];
    wire        to_dir = HADDR == {14'h0, `TCEIP_IDX_PORT0_DIR, 2'h0};

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    // ==========
    // Properties
    AST_READY_HIGH: assert property (HREADYOUT)
        else $error("hreadyout low");
    AST_OKAY_RESP: assert property (!HRESP)
        else $error("hresp not okay");
    AST_RESET_PINS: assert property ($rose(RESET_N) |->
        (PORT0_OE == 4'h0 && !COMPARE_MATCH_INTERRUPT)[*4])
        else $error("port or interrupt active after reset");
    AST_IRQ_PULSE: assert property (COMPARE_MATCH_INTERRUPT
        |=> !COMPARE_MATCH_INTERRUPT)
        else $error("interrupt longer than one cycle");
    AST_RDATA_IDLE: assert property (!$past(req & ~HWRITE) |->
        HRDATA == 32'h0)
        else $error("read data outside read data phase");
    AST_RDATA_WIDTH: assert property (HRDATA[31:20] == 12'h0)
        else $error("unused read data bits set");
    AST_DIR_UPPER: assert property (req & ~HWRITE & to_dir |=>
        HRDATA[7:4] == 4'hF)
        else $error("direction upper bits not one");
    AST_DIR_OE: assert property (req & HWRITE & to_dir |=> ##2
        PORT0_OE == ~$past(HWDATA[3:0], 2))
        else $error("enables do not follow direction bits");
endmodule

bind TCEIP_timer TCEIP_timer_chk u_chk (.*);

// ==== tb/tceip_src.sv ====
// Model of the pulse sources on the timer inputs and the port 0 pins.
// Assumes its tasks are called right after a rising edge.
`timescale 1ns/1ps

module TCEIP_src (
    input  logic       CLOCK,
    input  logic [3:0] PORT0_OE,
    input  logic [3:0] PORT0_OUT,
    output logic       FIRST_PIN,
    output logic [3:0] PORT0_PIN
);
    logic lvl_ff = 1'b0;

    assign FIRST_PIN = lvl_ff;
    assign PORT0_PIN = (PORT0_OE & PORT0_OUT) | (~PORT0_OE & {4{lvl_ff}});

    task automatic set_level(input logic v);
        lvl_ff <= v;
    endtask

    // Each level lasts w clocks, well past the two-clock minimum
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            lvl_ff <= 1'b1;
            repeat (w) @(posedge CLOCK);
            lvl_ff <= 1'b0;
            repeat (w) @(posedge CLOCK);
        end
    endtask
endmodule

// ==== tb/tceip_timer_tb.sv ====
// Self-checking testbench of the timer slice.
// Assumes the bound checker and the pulse source model.
`timescale 1ns/1ps
`include "tceip_consts.vh"

module TCEIP_timer_tb;
    logic        CLOCK;
    logic        RESET_N;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] rv;
    wire  [31:0] hrdata;
    wire         hready;
    wire         first_pin;
    wire  [3:0]  port_pin;
    wire  [3:0]  port_out;
    wire  [3:0]  port_oe;
    wire         irq;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          irq_cnt = 0;

    TCEIP_timer u_TCEIP_timer (
        .CLOCK(CLOCK), .RESET_N(RESET_N), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
        .FIRST_TIMER_INPUT(first_pin), .PORT0_IN(port_pin),
        .PORT0_OUT(port_out), .PORT0_OE(port_oe),
        .COMPARE_MATCH_INTERRUPT(irq));
    TCEIP_src u_TCEIP_src (
        .CLOCK(CLOCK), .PORT0_OE(port_oe), .PORT0_OUT(port_out),
        .FIRST_PIN(first_pin), .PORT0_PIN(port_pin));

    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    always @(negedge CLOCK) begin
        if (irq === 1'b1)
            irq_cnt++;
    end

    // ==========
    // Shared tasks
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge CLOCK);
        haddr  <= {14'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge CLOCK); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge CLOCK); while (hready !== 1'b1);
        rd = hrdata;
        @(posedge CLOCK);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, rv);
    endtask

    task automatic rd(input logic [15:0] idx);
        bus(1'b0, idx, 32'h0, rv);
    endtask

    task automatic irq_gap(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(negedge CLOCK);
            n++;
        end
        n = 0;
        do begin
            @(negedge CLOCK);
            n++;
        end while (irq !== 1'b1 && n < 2000);
    endtask

    task automatic run_len(input logic v, output int n);
        n = 0;
        while (port_out[1] === v && n < 99) begin
            @(negedge CLOCK);
            n++;
        end
    endtask

    // ==========
    // Scenarios
    task automatic t_reset;
        rd(`TCEIP_IDX_PORT0_DIR);
        chk("port0_direction", 32'hFF, rv);
        rd(`TCEIP_IDX_PRESCALE_EDGE);
        chk("timer_prescale_edge_mode", 32'h0, rv);
        chk("port enables", 32'h0, {28'h0, port_oe});
        rd(16'h0100);
        chk("unmapped", 32'h0, rv);
        wr(`TCEIP_IDX_PORT0_DIR, 32'hA);
        rd(`TCEIP_IDX_PORT0_DIR);
        chk("port0_direction", 32'hFA, rv);
        chk("port enables", 32'h5, {28'h0, port_oe});
        $display("test reset_and_direction done");
    endtask

    task automatic t_clock;
        int sel [4] = '{0, 0, 1, 2};
        int cmp [4] = '{3, 1, 1, 1};
        int per [4] = '{4, 2, 8, 512};
        int p;
        for (int i = 0; i < 4; i++) begin
            wr(`TCEIP_IDX_MODE_CTRL, 32'h0);
            wr(`TCEIP_IDX_FIRST_CMP, cmp[i]);
            wr(`TCEIP_IDX_PRESCALE_EDGE, sel[i]);
            wr(`TCEIP_IDX_MODE_CTRL, {30'h0, `TCEIP_MODE_INTERVAL});
            irq_gap(p);
            chk("interval", per[i], p);
        end
        rd(`TCEIP_IDX_STATUS);
        chk("overflow", 32'h0, {31'h0, rv[`TCEIP_ST_OVERFLOW]});
        $display("test clock_select_interval done");
    endtask

    task automatic t_edge;
        int es [3] = '{0, 1, 3};
        for (int i = 0; i < 3; i++) begin
            wr(`TCEIP_IDX_MODE_CTRL, 32'h0);
            wr(`TCEIP_IDX_STATUS, 32'h000F_0000);
            wr(`TCEIP_IDX_FIRST_CMP, 32'h1);
            wr(`TCEIP_IDX_PRESCALE_EDGE,
               {24'h0, es[i][1:0], es[i][1:0], 4'h3});
            wr(`TCEIP_IDX_MODE_CTRL, {30'h0, `TCEIP_MODE_INTERVAL});
            irq_cnt = 0;
            u_TCEIP_src.pulses(4, 6);
            repeat (10) @(posedge CLOCK);
            chk("edge ticks", es[i] == 3 ? 4 : 2, irq_cnt);
            rd(`TCEIP_IDX_STATUS);
            chk("second edge", 32'h1,
                {31'h0, rv[`TCEIP_ST_SECOND_EDGE]});
        end
        wr(`TCEIP_IDX_MODE_CTRL, 32'h0);
        $display("test external_edges done");
    endtask

    task automatic t_restart;
        u_TCEIP_src.set_level(1'b1);
        RESET_N <= 1'b0;
        repeat (3) @(posedge CLOCK);
        RESET_N <= 1'b1;
        wr(`TCEIP_IDX_PRESCALE_EDGE, 32'h13);
        wr(`TCEIP_IDX_MODE_CTRL, {30'h0, `TCEIP_MODE_FREE});
        repeat (10) @(posedge CLOCK);
        rd(`TCEIP_IDX_STATUS);
        chk("first start count", 32'h1, {16'h0, rv[15:0]});
        wr(`TCEIP_IDX_MODE_CTRL, 32'h0);
        wr(`TCEIP_IDX_MODE_CTRL, {30'h0, `TCEIP_MODE_FREE});
        repeat (10) @(posedge CLOCK);
        rd(`TCEIP_IDX_STATUS);
        chk("restart count", 32'h0, {16'h0, rv[15:0]});
        wr(`TCEIP_IDX_MODE_CTRL, 32'h0);
        u_TCEIP_src.set_level(1'b0);
        $display("test high_input_start done");
    endtask

    task automatic t_pulse;
        int hi;
        int lo;
        wr(`TCEIP_IDX_PORT0_LATCH, 32'h0);
        wr(`TCEIP_IDX_PORT0_DIR, 32'hD);
        wr(`TCEIP_IDX_FIRST_CMP, 32'h5);
        wr(`TCEIP_IDX_SECOND_CMP, 32'h2);
        wr(`TCEIP_IDX_OUTPUT_CTRL, 32'h1);
        wr(`TCEIP_IDX_PRESCALE_EDGE, 32'h0);
        wr(`TCEIP_IDX_MODE_CTRL, {30'h0, `TCEIP_MODE_PULSE});
        @(negedge CLOCK);
        run_len(1'b1, hi);
        run_len(1'b0, lo);
        run_len(1'b1, hi);
        run_len(1'b0, lo);
        chk("pulse high", 32'd3, hi);
        chk("pulse cycle", 32'd6, hi + lo);
        chk("shared pin enable", 32'h1, {31'h0, port_oe[1]});
        wr(`TCEIP_IDX_OUTPUT_CTRL, 32'h0);
        hi = 0;
        repeat (20) begin
            @(negedge CLOCK);
            if (port_out[1] !== 1'b0)
                hi++;
        end
        chk("disabled output", 32'h0, hi);
        wr(`TCEIP_IDX_MODE_CTRL, 32'h0);
        wr(`TCEIP_IDX_PORT0_DIR, 32'hF);
        $display("test pulse_output done");
    endtask

    task automatic t_wrap;
        wr(`TCEIP_IDX_STATUS, 32'h000F_0000);
        wr(`TCEIP_IDX_PRESCALE_EDGE, 32'h0);
        wr(`TCEIP_IDX_MODE_CTRL, {30'h0, `TCEIP_MODE_FREE});
        repeat (65540) @(posedge CLOCK);
        rd(`TCEIP_IDX_STATUS);
        chk("wrap overflow", 32'h1, {31'h0, rv[`TCEIP_ST_OVERFLOW]});
        wr(`TCEIP_IDX_MODE_CTRL, 32'h0);
        $display("test free_run_wrap done");
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        RESET_N = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (12) @(posedge CLOCK);
        RESET_N <= 1'b1;
        t_reset;
        t_clock;
        t_edge;
        t_restart;
        t_pulse;
        t_wrap;
        test_done;
    end

    initial begin
        repeat (90000) @(posedge CLOCK);
        num_errors++;
        $display("watchdog expired");
        test_done;
    end
endmodule
